// ### logic/onw_nibble_write.sv
/*
 Nibble write handler of a sensor bus node: decodes the nibble write
 command, updates mirror registers and one-time-programmable cells, builds
 the long response and keeps the user array integrity flag.
 Assumes command fields arrive as a one-cycle strobe from framing logic on
 the same clock, and that software stands in for the initialization command
 through the control register.
*/
`default_nettype none


module onw_nibble_write #(
	parameter int unsigned BIT_PROGRAM_CYCLES = onw_pkg::BIT_PROGRAM_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic cmd_valid,
	input wire onw_pkg::onw_fmt_t cmd_format,
	input wire logic [3:0] cmd_address,
	input wire logic [3:0] cmd_code,
	input wire logic [7:0] cmd_data,
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	output logic busy,
	output logic mismatch,
	output logic [3:0] node_address,
	output logic [1:0] lowpass_select,
	output logic identity_bit,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata
);

	// ==========================================================
	// Types and helpers
	typedef struct packed {
		logic hit;
		logic [3:0] idx;
		logic [7:0] mask;
		logic hi;
		logic [2:0] nbits;
	} onw_map_t;

	typedef struct packed {
		onw_pkg::onw_fsm_t fsm;
		logic [31:0] prog_count;
		logic program_enable_flag;
		logic [1:0] bank;
		logic [7:0] check_ref;
		logic [onw_pkg::NUM_BYTES-1:0][7:0] mirror;
		logic [onw_pkg::NUM_BYTES-1:0][7:0] otp;
		logic rsp_valid;
		logic [15:0] rsp_data;
		logic mismatch;
		logic [7:0] rdata;
	} onw_state_t;

	// Maps bank and nibble address onto a mirror byte and bit mask
	function automatic onw_map_t map_nibble(input logic [1:0] bank, input logic [3:0] wa);
		onw_map_t m;
		m = '{1'b0, 4'h0, 8'h00, 1'b0, 3'h0};
		case (bank)
			2'h0: begin
				case (wa)
					4'h7: m = '{1'b1, onw_pkg::IDX_CFG2, 8'h80, 1'b1, 3'h1};
					4'h8: m = '{1'b1, onw_pkg::IDX_TYPE, 8'hc0, 1'b1, 3'h2};
					4'ha: m = '{1'b1, onw_pkg::IDX_MAIN, 8'h80, 1'b1, 3'h1};
					default: m = '{1'b0, 4'h0, 8'h00, 1'b0, 3'h0};
				endcase
			end
			2'h1: begin
				if (wa == 4'h6) begin
					m = '{1'b1, onw_pkg::IDX_CFG1, 8'h03, 1'b0, 3'h2};
				end else if (wa == 4'h7) begin
					m = '{1'b1, onw_pkg::IDX_CFG2, 8'h0f, 1'b0, 3'h4};
				end else if (wa >= 4'h8 && wa <= 4'he) begin
					m = '{1'b1, 4'(wa - 4'h8 + onw_pkg::IDX_USER0), 8'h0f, 1'b0, 3'h4};
				end
			end
			2'h2: begin
				if (wa == 4'h7) begin
					m = '{1'b1, onw_pkg::IDX_CFG2, 8'h20, 1'b1, 3'h1};
				end else if (wa >= 4'h8) begin
					m = '{1'b1, 4'(wa - 4'h8 + onw_pkg::IDX_USER0), 8'hf0, 1'b1, 3'h4};
				end
			end
			default: m = '{1'b0, 4'h0, 8'h00, 1'b0, 3'h0};
		endcase
		return m;
	endfunction

	// Integrity value of the user array
	function automatic logic [7:0] check_of(input logic [onw_pkg::NUM_BYTES-1:0][7:0] b);
		logic [7:0] c;
		c = 8'h00;
		for (int i = onw_pkg::USER_FIRST; i <= onw_pkg::USER_LAST; i++) begin
			c = {c[6:0], c[7]} ^ b[i];
		end
		return c;
	endfunction

	function automatic logic [31:0] prog_cycles(input logic [2:0] nbits);
		return 32'(nbits) * 32'(BIT_PROGRAM_CYCLES);
	endfunction

	// ==========================================================
	// Command decode
	onw_state_t st;
	onw_state_t nx;
	onw_map_t cmd_map;
	logic accept;
	logic long_format;
	logic [7:0] place;
	logic [3:0] new_addr;
	logic [7:0] new_byte;
	logic [3:0] rd_nibble;

	assign node_address = st.mirror[onw_pkg::IDX_CFG2][3:0];
	assign lowpass_select = st.mirror[onw_pkg::IDX_TYPE][7:6];
	assign identity_bit = st.mirror[onw_pkg::IDX_MAIN][7];
	assign busy = (st.fsm == onw_pkg::ST_PROG);
	assign rsp_valid = st.rsp_valid;
	assign rsp_data = st.rsp_data;
	assign mismatch = st.mismatch;
	assign reg_rdata = st.rdata;

	assign long_format = (cmd_format == onw_pkg::FMT_STD_LONG) ||
		(cmd_format == onw_pkg::FMT_ENH_LONG);
	// Commands during programming are dropped; the master must wait
	assign accept = cmd_valid && !busy && long_format &&
		(cmd_code == onw_pkg::CMD_NIBBLE_WRITE) &&
		(cmd_address != onw_pkg::GLOBAL_ADDR) &&
		(cmd_address == node_address);
	assign cmd_map = map_nibble(st.bank, cmd_data[7:4]);
	assign place = cmd_map.hi ? {cmd_data[3:0], 4'h0} : {4'h0, cmd_data[3:0]};

	// ==========================================================
	// Next state
	always_comb begin
		nx = st;
		nx.rsp_valid = 1'b0;
		nx.rdata = 8'h00;
		new_addr = node_address;
		new_byte = 8'h00;
		rd_nibble = 4'h0;
		case (st.fsm)
			onw_pkg::ST_IDLE: begin
				if (accept) begin
					if (cmd_map.hit) begin
						// Mirror follows every write, user bytes included
						nx.mirror[cmd_map.idx] = (st.mirror[cmd_map.idx] & ~cmd_map.mask) |
							(place & cmd_map.mask);
						if (st.program_enable_flag) begin
							nx.otp[cmd_map.idx] = st.otp[cmd_map.idx] | (place & cmd_map.mask);
							nx.fsm = onw_pkg::ST_PROG;
							nx.prog_count = prog_cycles(cmd_map.nbits);
						end
					end
					new_addr = nx.mirror[onw_pkg::IDX_CFG2][3:0];
					new_byte = nx.mirror[cmd_map.idx];
					if (cmd_map.hit) begin
						rd_nibble = cmd_map.hi ? new_byte[7:4] : new_byte[3:0];
					end else begin
						rd_nibble = new_addr;
					end
					nx.rsp_valid = 1'b1;
					if (st.program_enable_flag) begin
						nx.rsp_data = {new_addr, cmd_data[7:4], onw_pkg::RSP_MARK,
							st.bank, rd_nibble};
					end else begin
						nx.rsp_data = {new_addr, onw_pkg::RSP_PLAIN_MID, new_addr};
					end
				end
			end
			onw_pkg::ST_PROG: begin
				if (st.prog_count <= 32'h1) begin
					nx.prog_count = onw_pkg::COUNT_RESET;
					nx.fsm = onw_pkg::ST_IDLE;
				end else begin
					nx.prog_count = st.prog_count - 32'h1;
				end
			end
			default: begin
				nx.fsm = onw_pkg::ST_IDLE;
				nx.prog_count = onw_pkg::COUNT_RESET;
			end
		endcase

		// Flag is only meaningful once the user array is locked
		nx.mismatch = st.mirror[onw_pkg::IDX_CFG2][onw_pkg::LOCK_BIT] &&
			(check_of(st.mirror) != st.check_ref);

		// ======================================================
		// Register port
		if (reg_write) begin
			case (reg_addr)
				onw_pkg::REG_CTRL: begin
					nx.program_enable_flag = reg_wdata[0];
					nx.bank = reg_wdata[2:1];
				end
				onw_pkg::REG_CHECK_REF: nx.check_ref = reg_wdata;
				default: nx.check_ref = st.check_ref;
			endcase
		end
		if (reg_read) begin
			if (reg_addr == onw_pkg::REG_CTRL) begin
				nx.rdata = {5'h00, st.bank, st.program_enable_flag};
			end else if (reg_addr == onw_pkg::REG_STATUS) begin
				nx.rdata = {6'h00, st.mismatch, busy};
			end else if (reg_addr == onw_pkg::REG_CHECK_REF) begin
				nx.rdata = st.check_ref;
			end else if (reg_addr == onw_pkg::REG_CHECK_VAL) begin
				nx.rdata = check_of(st.mirror);
			end else if (reg_addr >= onw_pkg::REG_MIRROR_BASE &&
				reg_addr < onw_pkg::REG_MIRROR_BASE + onw_pkg::REG_SPAN) begin
				nx.rdata = st.mirror[4'(reg_addr - onw_pkg::REG_MIRROR_BASE)];
			end else if (reg_addr >= onw_pkg::REG_OTP_BASE &&
				reg_addr < onw_pkg::REG_OTP_BASE + onw_pkg::REG_SPAN) begin
				nx.rdata = st.otp[4'(reg_addr - onw_pkg::REG_OTP_BASE)];
			end else begin
				nx.rdata = 8'h00;
			end
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk) begin
		if (reset) begin
			st.fsm <= onw_pkg::ST_IDLE;
			st.prog_count <= onw_pkg::COUNT_RESET;
			st.program_enable_flag <= 1'b0;
			st.bank <= 2'h0;
			st.check_ref <= onw_pkg::CHECK_REF_RESET;
			for (int i = 0; i < onw_pkg::NUM_BYTES; i++) begin
				st.mirror[i] <= onw_pkg::BYTE_RESET;
				st.otp[i] <= onw_pkg::BYTE_RESET;
			end
			st.mirror[onw_pkg::IDX_CFG2] <= onw_pkg::CFG2_RESET;
			st.rsp_valid <= 1'b0;
			st.rsp_data <= 16'h0000;
			st.mismatch <= 1'b0;
			st.rdata <= 8'h00;
		end else begin
			st <= nx;
		end
	end

	// ==========================================================
	// Checks
	logic [31:0] busy_len;
	logic [31:0] want_len;

	always_ff @(posedge clk) begin
		if (reset) begin
			busy_len <= 32'h0;
			want_len <= 32'h0;
		end else begin
			if (accept && st.program_enable_flag && cmd_map.hit) begin
				want_len <= prog_cycles(cmd_map.nbits);
			end
			busy_len <= busy ? busy_len + 32'h1 : 32'h0;
		end
	end

	sequence s_prog_write;
		accept && st.program_enable_flag && cmd_map.hit;
	endsequence

	sequence s_plain_write;
		accept && !st.program_enable_flag;
	endsequence

	sequence s_reply;
		rsp_valid;
	endsequence

	a_foreign_ignored: assert property (@(posedge clk) disable iff (reset)
		(cmd_valid && cmd_address != node_address) |=> !rsp_valid)
		else $error("reply to a command for another node");

	a_bank_echo: assert property (@(posedge clk) disable iff (reset)
		(accept && st.program_enable_flag) |=> s_reply ##0 (rsp_data[5:4] == $past(st.bank)))
		else $error("bank field not echoed");

	a_readback_value: assert property (@(posedge clk) disable iff (reset)
		s_prog_write |=> s_reply ##0 (rsp_data[3:0] == ($past(cmd_map.hi) ?
			st.mirror[$past(cmd_map.idx)][7:4] : st.mirror[$past(cmd_map.idx)][3:0])))
		else $error("reply data is not the written nibble");

	a_otp_guarded: assert property (@(posedge clk) disable iff (reset)
		!st.program_enable_flag |=> (st.otp == $past(st.otp)))
		else $error("OTP cells changed with programming disabled");

	a_plain_reply: assert property (@(posedge clk) disable iff (reset)
		s_plain_write |=> s_reply ##0 (rsp_data[11:4] == onw_pkg::RSP_PLAIN_MID &&
			rsp_data[15:12] == rsp_data[3:0]))
		else $error("reply layout wrong with programming disabled");

	a_new_address: assert property (@(posedge clk) disable iff (reset)
		s_reply |-> (rsp_data[15:12] == node_address))
		else $error("reply address is not the current node address");

	a_prog_time: assert property (@(posedge clk) disable iff (reset)
		$fell(busy) |-> (busy_len == want_len))
		else $error("programming time wrong");

	a_unassigned_nowrite: assert property (@(posedge clk) disable iff (reset)
		(accept && !cmd_map.hit) |=> (st.mirror == $past(st.mirror)) && !busy &&
			(rsp_data[3:0] == node_address))
		else $error("unassigned address wrote or replied wrongly");

	a_lock_gates_flag: assert property (@(posedge clk) disable iff (reset)
		!st.mirror[onw_pkg::IDX_CFG2][onw_pkg::LOCK_BIT] |=> !mismatch)
		else $error("mismatch flagged while unlocked");

	a_format_gate: assert property (@(posedge clk) disable iff (reset)
		(cmd_valid && (!long_format || cmd_address == onw_pkg::GLOBAL_ADDR)) |=> !rsp_valid)
		else $error("reply to a short or global command");

	a_user_update: assert property (@(posedge clk) disable iff (reset)
		(accept && cmd_map.hit && cmd_map.idx >= onw_pkg::IDX_USER0) |=>
			((st.mirror[$past(cmd_map.idx)] & $past(cmd_map.mask)) ==
			($past(place) & $past(cmd_map.mask))))
		else $error("user byte not updated");

	a_busy_drop: assert property (@(posedge clk) disable iff (reset)
		(cmd_valid && busy) |=> !rsp_valid && (st.mirror == $past(st.mirror)))
		else $error("command taken during programming");

	a_lock_only: assert property (@(posedge clk) disable iff (reset)
		(accept && st.bank == 2'h0 && cmd_data[7:4] == 4'h7) |=>
			(st.mirror[onw_pkg::IDX_CFG2][7] == $past(cmd_data[3])) &&
			(st.mirror[onw_pkg::IDX_CFG2][6:0] == $past(st.mirror[onw_pkg::IDX_CFG2][6:0])))
		else $error("lock bit write wrong");

	a_lowpass_write: assert property (@(posedge clk) disable iff (reset)
		(accept && st.bank == 2'h0 && cmd_data[7:4] == 4'h8) |=>
			(lowpass_select == $past(cmd_data[3:2])))
		else $error("low-pass select write wrong");

	a_identity_write: assert property (@(posedge clk) disable iff (reset)
		(accept && st.bank == 2'h0 && cmd_data[7:4] == 4'ha) |=>
			(identity_bit == $past(cmd_data[3])))
		else $error("identity bit write wrong");

	a_address_write: assert property (@(posedge clk) disable iff (reset)
		(accept && st.bank == 2'h1 && cmd_data[7:4] == 4'h7) |=>
			(node_address == $past(cmd_data[3:0])))
		else $error("node address write wrong");

	a_mode_write: assert property (@(posedge clk) disable iff (reset)
		(accept && st.bank == 2'h2 && cmd_data[7:4] == 4'h7) |=>
			(st.mirror[onw_pkg::IDX_CFG2][5] == $past(cmd_data[1])))
		else $error("mode bit write wrong");

endmodule

`default_nettype wire

// ### shared/onw_pkg.sv
/*
 Constants and types shared by the nibble write handler: command codes,
 command formats, mirror byte layout, register offsets, reset values and
 programming time.
 Assumes a 250 MHz system clock and an upstream framing block that has
 already checked the command frame.
*/
`default_nettype none

package onw_pkg;

	// ==========================================================
	// Command decoding
	typedef enum logic [1:0] {
		FMT_STD_LONG = 2'h0,
		FMT_STD_SHORT = 2'h1,
		FMT_ENH_LONG = 2'h2,
		FMT_ENH_SHORT = 2'h3
	} onw_fmt_t;

	localparam logic [3:0] CMD_NIBBLE_WRITE = 4'h9;
	localparam logic [3:0] GLOBAL_ADDR = 4'h0;
	localparam logic [1:0] RSP_MARK = 2'h3;
	localparam logic [7:0] RSP_PLAIN_MID = 8'h0f;

	// ==========================================================
	// Mirror byte layout
	localparam int NUM_BYTES = 12;
	localparam logic [3:0] IDX_MAIN = 4'h0;
	localparam logic [3:0] IDX_CFG1 = 4'h1;
	localparam logic [3:0] IDX_CFG2 = 4'h2;
	localparam logic [3:0] IDX_TYPE = 4'h3;
	localparam logic [3:0] IDX_USER0 = 4'h4;
	localparam int LOCK_BIT = 7;
	localparam int USER_FIRST = 4;
	localparam int USER_LAST = 11;

	// ==========================================================
	// Register offsets
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_STATUS = 5'h01;
	localparam logic [4:0] REG_CHECK_REF = 5'h02;
	localparam logic [4:0] REG_CHECK_VAL = 5'h03;
	localparam logic [4:0] REG_MIRROR_BASE = 5'h04;
	localparam logic [4:0] REG_OTP_BASE = 5'h10;
	localparam logic [4:0] REG_SPAN = 5'h0c;

	// ==========================================================
	// Reset values
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] CFG2_RESET = 8'h01;
	localparam logic [7:0] CHECK_REF_RESET = 8'h00;
	localparam logic [31:0] COUNT_RESET = 32'h0;

	// ==========================================================
	// Programming time
	localparam int BIT_PROGRAM_TIME_NS = 100000;
	localparam int CLK_PERIOD_NS = 4;
	localparam int BIT_PROGRAM_CYCLES = (BIT_PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Handler states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_PROG = 2'b10
	} onw_fsm_t;

endpackage

`default_nettype wire

// ### dv/onw_master.sv
/*
 Bus master model on the sensor daisy chain: sends commands to the node,
 collects the long response and waits out programming.
 Assumes the node registers its answer at the same edge that takes a command.
*/
`default_nettype none

module onw_master (
	input wire logic clk,
	input wire logic busy,
	input wire logic rsp_valid,
	input wire logic [15:0] rsp_data,
	output var logic cmd_valid,
	output var onw_pkg::onw_fmt_t cmd_format,
	output var logic [3:0] cmd_address,
	output var logic [3:0] cmd_code,
	output var logic [7:0] cmd_data
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		cmd_valid = 1'b0;
		cmd_format = onw_pkg::FMT_STD_LONG;
		cmd_address = 4'h0;
		cmd_code = 4'h0;
		cmd_data = 8'h00;
	end

	// ==========================================================
	// Command transfer
	task automatic send(input onw_pkg::onw_fmt_t fmt, input logic [3:0] adr,
			input logic [3:0] code, input logic [7:0] dat, output logic got,
			output logic [15:0] rsp, output int nbusy);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_format <= fmt;
		cmd_address <= adr;
		cmd_code <= code;
		cmd_data <= dat;
		@(posedge clk);
		cmd_valid <= 1'b0;
		// Released address, code and data fields do not keep the last value
		cmd_address <= ~adr;
		cmd_code <= ~code;
		cmd_data <= ~dat;
		#1;
		got = rsp_valid;
		rsp = rsp_data;
		nbusy = 0;
		// Next command only after programming has run out
		while (busy && nbusy < 1000) begin
			@(posedge clk);
			#1;
			nbusy++;
		end
	endtask
endmodule

`default_nettype wire

// ### dv/testbench.sv
/*
 Self-checking bench of the nibble write handler.
 Assumes a bus master model beside it and a short programming count.
*/
`default_nettype none

`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end

module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int PCYC = 3;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [4:0] reg_addr = 5'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	wire logic cmd_valid, rsp_valid, busy, mismatch, identity_bit;
	wire onw_pkg::onw_fmt_t cmd_format;
	wire logic [3:0] cmd_address, cmd_code, node_address;
	wire logic [7:0] cmd_data, reg_rdata;
	wire logic [15:0] rsp_data;
	wire logic [1:0] lowpass_select;
	int err_total = 0;
	int checks_done = 0;
	int nb;
	logic got;
	logic [15:0] rsp;
	logic [7:0] rv, v1;
	logic [31:0] tbl [10] = '{32'h00770601, 32'h00870740, 32'h00af0480, 32'h016f0503,
		32'h01960906, 32'h02fc0fc0, 32'h02720621, 32'h009f0480, 32'h038f0800, 32'h01ff0fc0};

	always #2 clk = ~clk;

	onw_master m (.clk(clk), .busy(busy), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.cmd_valid(cmd_valid), .cmd_format(cmd_format), .cmd_address(cmd_address),
		.cmd_code(cmd_code), .cmd_data(cmd_data));

	onw_nibble_write #(.BIT_PROGRAM_CYCLES(PCYC)) uut (.clk(clk), .reset(reset),
		.cmd_valid(cmd_valid), .cmd_format(cmd_format), .cmd_address(cmd_address),
		.cmd_code(cmd_code), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .busy(busy), .mismatch(mismatch), .node_address(node_address),
		.lowpass_select(lowpass_select), .identity_bit(identity_bit), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata));

	// ==========================================================
	// Register bus and command helpers
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic close_out;
		$display("Mismatches %0d, checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic cmd(input onw_pkg::onw_fmt_t f, input logic [3:0] a, input logic [3:0] c,
			input logic [7:0] d);
		m.send(f, a, c, d, got, rsp, nb);
		// A node stuck in programming ends the run
		if (nb >= 1000) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, nb, 4 * PCYC);
			close_out();
		end
	endtask

	task automatic nw(input logic [3:0] a, input logic [7:0] d);
		cmd(onw_pkg::FMT_STD_LONG, a, onw_pkg::CMD_NIBBLE_WRITE, d);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		rd(onw_pkg::REG_MIRROR_BASE + 5'h02, rv);
		`CHK(rv, 8'h01)
		`CHK(node_address, 4'h1)
		rd(5'h1f, rv);
		`CHK(rv, 8'h00)
	endtask

	task automatic t_table;
		foreach (tbl[i]) begin
			wr(onw_pkg::REG_CTRL, {5'h00, tbl[i][25:24], 1'b0});
			nw(4'h1, tbl[i][23:16]);
			`CHK(got, 1'b1)
			`CHK(rsp, 16'h10f1)
			rd(tbl[i][12:8], rv);
			`CHK(rv, tbl[i][7:0])
		end
		`CHK(lowpass_select, 2'h1)
		`CHK(identity_bit, 1'b1)
		rd(onw_pkg::REG_OTP_BASE + 5'h02, rv);
		`CHK(rv, 8'h00)
	endtask

	task automatic refused(input onw_pkg::onw_fmt_t f, input logic [3:0] a,
			input logic [3:0] c);
		cmd(f, a, c, 8'h5f);
		`CHK(got, 1'b0)
	endtask

	task automatic t_refuse;
		wr(onw_pkg::REG_CTRL, 8'h00);
		refused(onw_pkg::FMT_STD_LONG, 4'h2, 4'h9);
		refused(onw_pkg::FMT_STD_LONG, 4'h0, 4'h9);
		refused(onw_pkg::FMT_STD_SHORT, 4'h1, 4'h9);
		refused(onw_pkg::FMT_ENH_SHORT, 4'h1, 4'h9);
		refused(onw_pkg::FMT_STD_LONG, 4'h1, 4'h8);
		cmd(onw_pkg::FMT_ENH_LONG, 4'h1, 4'h9, 8'h5f);
		`CHK(got, 1'b1)
	endtask

	task automatic t_prog;
		wr(onw_pkg::REG_CTRL, 8'h03);
		nw(4'h1, 8'h8a);
		`CHK(rsp, 16'h18da)
		`CHK(nb, 4 * PCYC)
		rd(onw_pkg::REG_OTP_BASE + 5'h04, rv);
		`CHK(rv, 8'h0a)
		nw(4'h1, 8'h05);
		`CHK(rsp, 16'h10d1)
		`CHK(nb, 0)
		wr(onw_pkg::REG_CTRL, 8'h01);
		nw(4'h1, 8'h70);
		`CHK(rsp, 16'h17c2)
		`CHK(nb, PCYC)
	endtask

	task automatic t_check;
		wr(onw_pkg::REG_CTRL, 8'h02);
		rd(onw_pkg::REG_CHECK_VAL, v1);
		nw(4'h1, 8'h85);
		rd(onw_pkg::REG_CHECK_VAL, rv);
		`CHK(rv !== v1, 1'b1)
		wr(onw_pkg::REG_CHECK_REF, rv ^ 8'h01);
		repeat (2) @(posedge clk);
		#1;
		`CHK(mismatch, 1'b0)
		wr(onw_pkg::REG_CTRL, 8'h00);
		nw(4'h1, 8'h78);
		repeat (2) @(posedge clk);
		#1;
		`CHK(mismatch, 1'b1)
		wr(onw_pkg::REG_CHECK_REF, rv);
		repeat (2) @(posedge clk);
		#1;
		`CHK(mismatch, 1'b0)
	endtask

	task automatic t_addr;
		wr(onw_pkg::REG_CTRL, 8'h02);
		nw(4'h1, 8'h75);
		`CHK(rsp, 16'h50f5)
		`CHK(node_address, 4'h5)
		nw(4'h1, 8'h75);
		`CHK(got, 1'b0)
	endtask

	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_table();
		t_refuse();
		t_prog();
		t_check();
		t_addr();
		close_out();
	end
endmodule

`default_nettype wire
